// ---- core/pch_pkg.sv ----
// Shared constants and types for the upper header block.
// Assumes one clock and a 32-bit data path.
package pch_pkg;
  // Configuration dword offsets, byte addressed.
  localparam logic [7:0] PCH_OFF_HDR = 8'h0c;
  localparam logic [7:0] PCH_OFF_MEM0 = 8'h10;
  localparam logic [7:0] PCH_OFF_MEM1 = 8'h14;
  localparam logic [7:0] PCH_OFF_IO = 8'h18;
  localparam logic [7:0] PCH_OFF_CODES = 8'h2c;
  localparam logic [7:0] PCH_OFF_ROM = 8'h30;
  localparam logic [7:0] PCH_OFF_CAP = 8'h34;
  localparam logic [7:0] PCH_OFF_INTR = 8'h3c;
  // Fixed and reset values.
  localparam logic [7:0] PCH_HDR_FORMAT = 8'h00;
  localparam logic [7:0] PCH_SELF_TEST = 8'h00;
  localparam logic [7:0] PCH_INT_LINE_RST = 8'h05;
  localparam logic [7:0] PCH_INT_PIN = 8'h01;
  localparam logic [7:0] PCH_MIN_GNT = 8'h00;
  localparam logic [7:0] PCH_MAX_LAT = 8'h00;
  localparam logic [31:0] PCH_MEM0_RST = 32'hf8000000;
  localparam logic [31:0] PCH_MEM1_RST = 32'hf8000008;
  localparam logic [31:0] PCH_IO_RST = 32'hffffff01;
  localparam logic [31:0] PCH_ROM32_RST = 32'hffff8000;
  localparam logic [31:0] PCH_ROM64_RST = 32'hffff0000;
  localparam logic [31:0] PCH_CAP_AGP = 32'h00000054;
  localparam logic [31:0] PCH_CAP_NO_AGP = 32'h00000060;
  // Sizing probes and window masks.
  localparam logic [31:0] PCH_ALL_ONES = 32'hffffffff;
  localparam logic [31:0] PCH_ROM_PROBE = 32'hfffffffe;
  localparam logic [31:0] PCH_MEM_MASK = 32'hfe000000;
  localparam logic [31:0] PCH_IO_MASK = 32'hffffff00;
  localparam logic [31:0] PCH_ROM_DEC_MASK = 32'hffff0000;
  localparam logic [31:0] PCH_ROM32_WR_MASK = 32'hffff8000;
  // Boot ROM location of the first board code byte.
  localparam logic [15:0] PCH_ROM32_CODE_BASE = 16'h7ff8;
  localparam logic [15:0] PCH_ROM64_CODE_BASE = 16'hfff8;
  localparam logic [1:0] PCH_STRAP_SETTLE = 2'h2;
  // Host register offsets and fields.
  localparam logic [7:0] PCH_H_ADDR = 8'h00;
  localparam logic [7:0] PCH_H_WDATA = 8'h04;
  localparam logic [7:0] PCH_H_CTRL = 8'h08;
  localparam logic [7:0] PCH_H_STATUS = 8'h0c;
  localparam logic [7:0] PCH_H_RDATA = 8'h10;
  localparam int PCH_CTRL_GO = 8;
  localparam logic [1:0] PCH_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCH_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PCH_CMD_CFG_RD = 2'h0,
    PCH_CMD_CFG_WR = 2'h1,
    PCH_CMD_MEM = 2'h2,
    PCH_CMD_IO = 2'h3
  } pch_cmd_t;

  typedef enum logic [2:0] {
    PCH_WIN_NONE = 3'h0,
    PCH_WIN_MEM0 = 3'h1,
    PCH_WIN_MEM1 = 3'h2,
    PCH_WIN_IO = 3'h3,
    PCH_WIN_ROM = 3'h4
  } pch_win_t;

  function automatic logic [31:0] pch_merge(logic [31:0] old, logic [31:0] wd,
    logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction
endpackage

// ---- core/pch_link_if.sv ----
// Link between the host end and the device end.
// Assumes both ends share one aclk.
`timescale 1ns/1ns
interface pch_link_if;
  logic req_valid;
  logic req_ready;
  pch_pkg::pch_cmd_t req_cmd;
  logic [31:0] req_addr;
  logic [3:0] req_be;
  logic [31:0] req_wdata;
  logic rsp_valid;
  logic rsp_claim;
  logic [31:0] rsp_rdata;

  modport dev(
    input req_valid, req_cmd, req_addr, req_be, req_wdata,
    output req_ready, rsp_valid, rsp_claim, rsp_rdata
  );
  modport host(
    output req_valid, req_cmd, req_addr, req_be, req_wdata,
    input req_ready, rsp_valid, rsp_claim, rsp_rdata
  );
endinterface

// ---- core/pch_dev.sv ----
// Device end: upper header fields, window decode, board code load.
// Assumes a same-clock host, a byte-wide boot ROM that answers in its
// own time, and asynchronous strap pins.
//
// Overview of operation
// - Header format low seven bits read zero.
// - Header format bit 7 reads zero.
// - Self-test byte reads zero, ignores writes.
// - All-ones write restores memory window base.
// - Memory windows decode address bits 31..25.
// - Memory bases reset to fixed values.
// - All-ones write restores I/O window base.
// - I/O window decodes address bits 31..8.
// - I/O base resets to fixed value.
// - Board maker code loads from ROM.
// - Board type code loads from ROM.
// - Expansion code rewrites both board codes.
// - Probe write restores ROM window base.
// - ROM size strapped; decode bits 31..16.
// - ROM base reset follows strapped size.
// - Capability start depends on AGP strap.
// - Interrupt routing number resets to five.
// - Interrupt line select reads one.
// - Grant and latency bytes read zero.
// - Command enables gate memory and I/O.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module pch_dev
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the host end
  pch_link_if.dev link,
  // Strap pins, asynchronous
  input wire logic strap_rom_64k,
  input wire logic strap_agp_en,
  // Enables from the lower header command register
  input wire logic cmd_io_en,
  input wire logic cmd_mem_en,
  // Boot ROM byte reader
  output logic rom_rd,
  output logic [15:0] rom_addr,
  input wire logic [7:0] rom_rdata,
  input wire logic rom_rvalid,
  // Decode result toward the data path
  output logic win_hit,
  output pch_pkg::pch_win_t win_sel
);
  import pch_pkg::*;

  typedef enum logic [3:0] {
    D_STRAP = 4'b0001,
    D_LOAD = 4'b0010,
    D_WAIT = 4'b0100,
    D_RUN = 4'b1000
  } pch_dst_t;

  typedef struct packed {
    pch_dst_t st;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] idx;
    logic rom_big;
    logic agp;
    logic [31:0] mem0;
    logic [31:0] mem1;
    logic [31:0] io;
    logic [31:0] rom;
    logic [31:0] codes;
    logic [7:0] intline;
    logic rom_rd;
    logic [15:0] rom_addr;
    logic ready;
    logic rsp_valid;
    logic rsp_claim;
    logic [31:0] rsp_rdata;
    logic hit;
    pch_win_t win;
  } pch_dstate_t;

  pch_dstate_t r;
  pch_dstate_t next_r;

  // Base registers keep their low bits at the reset value, so a sizing read
  // after the probe shows the window size.
  function automatic logic [31:0] bar_wr(logic [31:0] old, logic [31:0] wd,
    logic [3:0] be, logic [31:0] mask, logic [31:0] rst, logic [31:0] probe);
    if (be == 4'hf && wd == probe)
    begin
      return rst;
    end
    return (pch_merge(old, wd, be) & mask) | (rst & ~mask);
  endfunction

  function automatic logic win_match(logic [31:0] a, logic [31:0] base,
    logic [31:0] mask);
    return ((a ^ base) & mask) == 32'h0;
  endfunction

  always_comb
  begin
    logic [31:0] rst_rom;
    logic [31:0] wr_rom;
    logic [7:0] off;
    logic [31:0] a;
    logic [31:0] wd;
    rst_rom = r.rom_big ? PCH_ROM64_RST : PCH_ROM32_RST;
    wr_rom = r.rom_big ? PCH_ROM_DEC_MASK : PCH_ROM32_WR_MASK;
    off = {link.req_addr[7:2], 2'b00};
    a = link.req_addr;
    wd = link.req_wdata;
    next_r = r;
    // Straps pass two flops before use.
    next_r.s1 = {strap_rom_64k, strap_agp_en};
    next_r.s2 = r.s1;
    next_r.rom_rd = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.hit = 1'b0;
    unique case (r.st)
      D_STRAP:
      begin
        next_r.idx = r.idx + 2'h1;
        if (r.idx == PCH_STRAP_SETTLE)
        begin
          next_r.rom_big = r.s2[1];
          next_r.agp = r.s2[0];
          next_r.rom = r.s2[1] ? PCH_ROM64_RST : PCH_ROM32_RST;
          next_r.idx = 2'h0;
          next_r.st = D_LOAD;
        end
      end
      D_LOAD:
      begin
        next_r.rom_rd = 1'b1;
        next_r.rom_addr = (r.rom_big ? PCH_ROM64_CODE_BASE : PCH_ROM32_CODE_BASE)
          + {14'h0, r.idx};
        next_r.st = D_WAIT;
      end
      D_WAIT:
      begin
        if (rom_rvalid)
        begin
          // Byte order maker low, maker high, type low, type high.
          next_r.codes[8*r.idx +: 8] = rom_rdata;
          if (r.idx == 2'h3)
          begin
            next_r.ready = 1'b1;
            next_r.st = D_RUN;
          end
          else
          begin
            next_r.idx = r.idx + 2'h1;
            next_r.st = D_LOAD;
          end
        end
      end
      D_RUN:
      begin
        next_r.ready = 1'b1;
        if (r.ready && link.req_valid)
        begin
          // One request in flight; ready drops for the answer cycle.
          next_r.ready = 1'b0;
          next_r.rsp_valid = 1'b1;
          next_r.rsp_claim = 1'b0;
          next_r.rsp_rdata = 32'h0;
          next_r.win = PCH_WIN_NONE;
          unique case (link.req_cmd)
            PCH_CMD_CFG_RD:
            begin
              next_r.rsp_claim = 1'b1;
              case (off)
                PCH_OFF_HDR: next_r.rsp_rdata = {PCH_SELF_TEST, PCH_HDR_FORMAT, 16'h0};
                PCH_OFF_MEM0: next_r.rsp_rdata = r.mem0;
                PCH_OFF_MEM1: next_r.rsp_rdata = r.mem1;
                PCH_OFF_IO: next_r.rsp_rdata = r.io;
                PCH_OFF_CODES: next_r.rsp_rdata = r.codes;
                PCH_OFF_ROM: next_r.rsp_rdata = r.rom;
                PCH_OFF_CAP: next_r.rsp_rdata = r.agp ? PCH_CAP_AGP : PCH_CAP_NO_AGP;
                PCH_OFF_INTR:
                begin
                  next_r.rsp_rdata = {PCH_MAX_LAT, PCH_MIN_GNT, PCH_INT_PIN, r.intline};
                end
                default: next_r.rsp_rdata = 32'h0;
              endcase
            end
            PCH_CMD_CFG_WR:
            begin
              // Fixed fields have no storage, so writes to them fall away.
              next_r.rsp_claim = 1'b1;
              case (off)
                PCH_OFF_MEM0:
                begin
                  next_r.mem0 = bar_wr(r.mem0, wd, link.req_be, PCH_MEM_MASK, PCH_MEM0_RST,
                    PCH_ALL_ONES);
                end
                PCH_OFF_MEM1:
                begin
                  next_r.mem1 = bar_wr(r.mem1, wd, link.req_be, PCH_MEM_MASK, PCH_MEM1_RST,
                    PCH_ALL_ONES);
                end
                PCH_OFF_IO:
                begin
                  next_r.io = bar_wr(r.io, wd, link.req_be, PCH_IO_MASK, PCH_IO_RST,
                    PCH_ALL_ONES);
                end
                PCH_OFF_CODES: next_r.codes = pch_merge(r.codes, wd, link.req_be);
                PCH_OFF_ROM:
                begin
                  next_r.rom = bar_wr(r.rom, wd, link.req_be, wr_rom, rst_rom,
                    PCH_ROM_PROBE);
                end
                PCH_OFF_INTR:
                begin
                  if (link.req_be[0])
                  begin
                    next_r.intline = wd[7:0];
                  end
                end
                default: next_r.rsp_claim = 1'b1;
              endcase
            end
            PCH_CMD_MEM:
            begin
              if (cmd_mem_en)
              begin
                if (win_match(a, r.mem0, PCH_MEM_MASK))
                begin
                  next_r.win = PCH_WIN_MEM0;
                end
                else if (win_match(a, r.mem1, PCH_MEM_MASK))
                begin
                  next_r.win = PCH_WIN_MEM1;
                end
                else if (win_match(a, r.rom, PCH_ROM_DEC_MASK))
                begin
                  next_r.win = PCH_WIN_ROM;
                end
              end
              next_r.hit = next_r.win != PCH_WIN_NONE;
              next_r.rsp_claim = next_r.hit;
            end
            PCH_CMD_IO:
            begin
              if (cmd_io_en && win_match(a, r.io, PCH_IO_MASK))
              begin
                next_r.win = PCH_WIN_IO;
                next_r.hit = 1'b1;
                next_r.rsp_claim = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= D_STRAP;
      r.mem0 <= PCH_MEM0_RST;
      r.mem1 <= PCH_MEM1_RST;
      r.io <= PCH_IO_RST;
      r.rom <= PCH_ROM64_RST;
      r.intline <= PCH_INT_LINE_RST;
      r.win <= PCH_WIN_NONE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.req_ready = r.ready;
  assign link.rsp_valid = r.rsp_valid;
  assign link.rsp_claim = r.rsp_claim;
  assign link.rsp_rdata = r.rsp_rdata;
  assign rom_rd = r.rom_rd;
  assign rom_addr = r.rom_addr;
  assign win_hit = r.hit;
  assign win_sel = r.win;
endmodule

// ---- core/pch_host.sv ----
// Host end: turns AXI4-Lite register orders into configuration, memory
// and I/O cycles on the link. Assumes the device end on the same aclk.
`timescale 1ns/1ns
module pch_host
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the device end
  pch_link_if.host link,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import pch_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_REQ = 3'b010,
    H_RSP = 3'b100
  } pch_hst_t;

  typedef struct packed {
    pch_hst_t st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdat;
    logic [31:0] taddr;
    logic [31:0] twdata;
    pch_cmd_t cmd;
    logic [3:0] be;
    logic done;
    logic claim;
    logic [31:0] rsp;
    logic req_valid;
  } pch_hstate_t;

  pch_hstate_t r;
  pch_hstate_t next_r;

  always_comb
  begin
    logic busy;
    busy = r.st != H_IDLE;
    next_r = r;
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_awvalid && r.awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdat = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    unique case (r.st)
      H_IDLE: next_r.st = H_IDLE;
      H_REQ:
      begin
        if (link.req_ready)
        begin
          next_r.req_valid = 1'b0;
          next_r.st = H_RSP;
        end
      end
      H_RSP:
      begin
        if (link.rsp_valid)
        begin
          next_r.done = 1'b1;
          next_r.claim = link.rsp_claim;
          next_r.rsp = link.rsp_rdata;
          next_r.st = H_IDLE;
        end
      end
    endcase
    // Orders are frozen while a cycle is out, so the link payload holds.
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = PCH_RESP_OKAY;
      case (r.awaddr)
        PCH_H_ADDR:
        begin
          if (!busy)
          begin
            next_r.taddr = pch_merge(r.taddr, r.wdat, r.wstrb);
          end
        end
        PCH_H_WDATA:
        begin
          if (!busy)
          begin
            next_r.twdata = pch_merge(r.twdata, r.wdat, r.wstrb);
          end
        end
        PCH_H_CTRL:
        begin
          if (!busy && r.wstrb[0])
          begin
            next_r.cmd = pch_cmd_t'(r.wdat[1:0]);
            next_r.be = r.wdat[7:4];
          end
          if (!busy && r.wstrb[1] && r.wdat[PCH_CTRL_GO])
          begin
            next_r.req_valid = 1'b1;
            next_r.done = 1'b0;
            next_r.st = H_REQ;
          end
        end
        default: next_r.bresp = PCH_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && r.arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = PCH_RESP_OKAY;
      case (s_axi_araddr)
        PCH_H_ADDR: next_r.rdat = r.taddr;
        PCH_H_WDATA: next_r.rdat = r.twdata;
        PCH_H_CTRL: next_r.rdat = {24'h0, r.be, 2'h0, r.cmd};
        PCH_H_STATUS: next_r.rdat = {29'h0, r.claim, r.done, busy};
        PCH_H_RDATA: next_r.rdat = r.rsp;
        default:
        begin
          next_r.rdat = 32'h0;
          next_r.rresp = PCH_RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= H_IDLE;
      r.cmd <= PCH_CMD_CFG_RD;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.req_valid = r.req_valid;
  assign link.req_cmd = r.cmd;
  assign link.req_addr = r.taddr;
  assign link.req_be = r.be;
  assign link.req_wdata = r.twdata;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdat;
  assign s_axi_rresp = r.rresp;
endmodule

// ---- testbench/pch_checker.sv ----
// Concurrent checks on the link between host end and device end.
// Assumes one link instance on the shared clock and reset.
`timescale 1ns/1ns
module pch_checker
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pch_pkg::pch_cmd_t req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  // Link answer
  input wire logic rsp_valid,
  input wire logic rsp_claim,
  input wire logic [31:0] rsp_rdata
);
  import pch_pkg::*;
  pch_cmd_t t_cmd;
  logic [7:0] t_off;
  logic [7:0] w_off;
  logic mem0_probe, io_probe, rom_probe, rd_ok, cfg_wr, full_wr;

  // The answer refers to the request taken one edge earlier, so keep it.
  assign w_off = {req_addr[7:2], 2'b00};
  assign cfg_wr = req_cmd == PCH_CMD_CFG_WR;
  assign full_wr = req_be == 4'hf;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t_cmd <= PCH_CMD_CFG_RD;
      t_off <= 8'h00;
      mem0_probe <= 1'b0;
      io_probe <= 1'b0;
      rom_probe <= 1'b0;
    end
    else if (req_valid && req_ready)
    begin
      t_cmd <= req_cmd;
      t_off <= w_off;
      if (cfg_wr && w_off == PCH_OFF_MEM0)
        mem0_probe <= full_wr && req_wdata == PCH_ALL_ONES;
      if (cfg_wr && w_off == PCH_OFF_IO)
        io_probe <= full_wr && req_wdata == PCH_ALL_ONES;
      if (cfg_wr && w_off == PCH_OFF_ROM)
        rom_probe <= full_wr && req_wdata == PCH_ROM_PROBE;
    end
  end
  assign rd_ok = rsp_valid && (t_cmd == PCH_CMD_CFG_RD);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_answer;
    req_valid && req_ready |=> rsp_valid && !req_ready ##1 !rsp_valid && req_ready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("late answer");
  property p_cause;
    rsp_valid |-> $past(req_valid) && $past(req_ready);
  endproperty
  a_cause: assert property (p_cause)
    else $error("stray answer");
  property p_claim_hold;
    !rsp_valid |-> $stable(rsp_claim);
  endproperty
  a_claim_hold: assert property (p_claim_hold)
    else $error("claim moved");
  property p_hdr_zero;
    rd_ok && t_off == PCH_OFF_HDR |-> rsp_rdata == 32'h0;
  endproperty
  a_hdr_zero: assert property (p_hdr_zero)
    else $error("header not zero");
  property p_intr_fixed;
    rd_ok && t_off == PCH_OFF_INTR |-> rsp_rdata[31:8] == 24'h000001;
  endproperty
  a_intr_fixed: assert property (p_intr_fixed)
    else $error("intr bytes wrong");
  property p_cap;
    rd_ok && t_off == PCH_OFF_CAP |-> rsp_rdata == 32'h54 || rsp_rdata == 32'h60;
  endproperty
  a_cap: assert property (p_cap)
    else $error("cap start wrong");
  property p_mem0_probe;
    rd_ok && t_off == PCH_OFF_MEM0 && mem0_probe |-> rsp_rdata == 32'hf8000000;
  endproperty
  a_mem0_probe: assert property (p_mem0_probe)
    else $error("mem0 not restored");
  property p_io_probe;
    rd_ok && t_off == PCH_OFF_IO && io_probe |-> rsp_rdata == 32'hffffff01;
  endproperty
  a_io_probe: assert property (p_io_probe)
    else $error("io not restored");
  property p_rom_probe;
    rd_ok && t_off == PCH_OFF_ROM && rom_probe |-> rsp_rdata inside {32'hffff8000, 32'hffff0000};
  endproperty
  a_rom_probe: assert property (p_rom_probe)
    else $error("rom not restored");
  property p_mem_low;
    rd_ok && t_off == PCH_OFF_MEM1 |-> rsp_rdata[24:0] == 25'h8;
  endproperty
  a_mem_low: assert property (p_mem_low)
    else $error("mem1 low bits wrong");
  property p_io_low;
    rd_ok && t_off == PCH_OFF_IO |-> rsp_rdata[7:0] == 8'h01;
  endproperty
  a_io_low: assert property (p_io_low)
    else $error("io low bits wrong");
  property p_rom_low;
    rd_ok && t_off == PCH_OFF_ROM |-> rsp_rdata[14:0] == 15'h0;
  endproperty
  a_rom_low: assert property (p_rom_low)
    else $error("rom low bits wrong");

  c_mem0_probe: cover property (rd_ok && mem0_probe);
  c_io_claim: cover property (rsp_valid && rsp_claim && t_cmd == PCH_CMD_IO);
  c_rom_probe: cover property (rd_ok && rom_probe);
endmodule

// ---- testbench/pci_config_header_upper_tb.sv ----
// Testbench: AXI4-Lite orders to the host end, which runs link cycles
// on the device end. A simple boot ROM answers reads.
`timescale 1ns/1ns
module pci_config_header_upper_tb;
  import pch_pkg::*;
  logic aclk, aresetn, strap_rom_64k, strap_agp_en, cmd_io_en, cmd_mem_en;
  logic rom_rd, rom_rvalid, win_hit;
  logic [15:0] rom_addr;
  logic [7:0] rom_rdata;
  logic [1:0] rom_cnt, last_resp;
  pch_win_t win_sel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors, checks_done;

  pch_link_if link();
  pch_dev pch_dev_inst(.*);
  pch_host pch_host_inst(.*);
  pch_checker pch_checker_inst(.aclk(aclk), .aresetn(aresetn), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_cmd(link.req_cmd), .req_addr(link.req_addr),
    .req_be(link.req_be), .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid),
    .rsp_claim(link.rsp_claim), .rsp_rdata(link.rsp_rdata));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Each ROM byte encodes its own address, so a wrong fetch address shows.
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [31:0] codes(input logic [15:0] b);
    return {rom_byte(b + 16'h3), rom_byte(b + 16'h2), rom_byte(b + 16'h1), rom_byte(b)};
  endfunction

  // Slow ROM: three cycles per byte; the data lines toggle while idle.
  always @(posedge aclk)
  begin
    rom_rvalid <= aresetn && rom_cnt == 2'h1;
    rom_rdata <= (rom_cnt == 2'h1) ? rom_byte(rom_addr) : ~rom_rdata;
    rom_cnt <= !aresetn ? 2'h0 : rom_rd ? 2'h3 : rom_cnt - {1'b0, rom_cnt != 2'h0};
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic op(input pch_cmd_t c, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic claim);
    logic [31:0] st;
    axi_wr(PCH_H_ADDR, a);
    axi_wr(PCH_H_WDATA, wd);
    axi_wr(PCH_H_CTRL, {23'h0, 1'b1, 4'hf, 2'h0, c});
    do axi_rd(PCH_H_STATUS, st); while (st[1] !== 1'b1);
    axi_rd(PCH_H_RDATA, rd);
    claim = st[2];
  endtask

  task automatic cfg_rd(input logic [7:0] o, input logic [31:0] exp);
    logic [31:0] d;
    logic cl;
    op(PCH_CMD_CFG_RD, {24'h0, o}, 32'h0, d, cl);
    check($sformatf("config dword %h", o), d, exp);
  endtask

  task automatic cfg_wr(input logic [7:0] o, input logic [31:0] wd);
    logic [31:0] d;
    logic cl;
    op(PCH_CMD_CFG_WR, {24'h0, o}, wd, d, cl);
  endtask

  task automatic cyc(input pch_cmd_t c, input logic [31:0] a, input logic hit, input pch_win_t w);
    logic [31:0] d;
    logic cl;
    op(c, a, 32'h0, d, cl);
    check($sformatf("claim at %h", a), {31'h0, cl}, {31'h0, hit});
    check($sformatf("window at %h", a), {29'h0, win_sel}, {29'h0, w});
  endtask

  task automatic do_reset(input logic big, input logic agp);
    aresetn <= 1'b0;
    strap_rom_64k <= big;
    strap_agp_en <= agp;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmd_io_en, cmd_mem_en, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {num_errors, checks_done} = '0;
    @(posedge aclk);
    do_reset(1'b0, 1'b1);
    cfg_rd(PCH_OFF_HDR, 32'h0);
    cfg_rd(PCH_OFF_MEM0, 32'hf8000000);
    cfg_rd(PCH_OFF_MEM1, 32'hf8000008);
    cfg_rd(PCH_OFF_IO, 32'hffffff01);
    cfg_rd(PCH_OFF_CODES, codes(16'h7ff8));
    cfg_rd(PCH_OFF_ROM, 32'hffff8000);
    cfg_rd(PCH_OFF_CAP, 32'h00000054);
    cfg_rd(PCH_OFF_INTR, 32'h00000105);
    $display("test reset values done");
    cfg_wr(PCH_OFF_HDR, 32'hffffffff);
    cfg_rd(PCH_OFF_HDR, 32'h0);
    cfg_wr(PCH_OFF_CAP, 32'hffffffff);
    cfg_rd(PCH_OFF_CAP, 32'h00000054);
    cfg_wr(PCH_OFF_INTR, 32'hffffffff);
    cfg_rd(PCH_OFF_INTR, 32'h000001ff);
    cfg_wr(PCH_OFF_CODES, 32'hbeefcafe);
    cfg_rd(PCH_OFF_CODES, 32'hbeefcafe);
    axi_rd(8'h20, rdv);
    check("unmapped read response", {30'h0, last_resp}, {30'h0, PCH_RESP_SLVERR});
    $display("test fixed fields done");
    cfg_wr(PCH_OFF_MEM1, 32'h20000000);
    cfg_rd(PCH_OFF_MEM1, 32'h20000008);
    cfg_wr(PCH_OFF_MEM0, 32'h12345678);
    cfg_rd(PCH_OFF_MEM0, 32'h12000000);
    cyc(PCH_CMD_MEM, 32'h13ffffff, 1'b1, PCH_WIN_MEM0);
    cyc(PCH_CMD_MEM, 32'h14000000, 1'b0, PCH_WIN_NONE);
    cyc(PCH_CMD_MEM, 32'h21fffffc, 1'b1, PCH_WIN_MEM1);
    cmd_mem_en <= 1'b0;
    cyc(PCH_CMD_MEM, 32'h12000000, 1'b0, PCH_WIN_NONE);
    cmd_mem_en <= 1'b1;
    cfg_wr(PCH_OFF_MEM0, 32'hffffffff);
    cfg_rd(PCH_OFF_MEM0, 32'hf8000000);
    cfg_wr(PCH_OFF_MEM1, 32'hffffffff);
    cfg_rd(PCH_OFF_MEM1, 32'hf8000008);
    $display("test memory windows done");
    cfg_wr(PCH_OFF_IO, 32'h0000abff);
    cfg_rd(PCH_OFF_IO, 32'h0000ab01);
    cyc(PCH_CMD_IO, 32'h0000abff, 1'b1, PCH_WIN_IO);
    cyc(PCH_CMD_IO, 32'h0000ac00, 1'b0, PCH_WIN_NONE);
    cmd_io_en <= 1'b0;
    cyc(PCH_CMD_IO, 32'h0000ab00, 1'b0, PCH_WIN_NONE);
    cmd_io_en <= 1'b1;
    cfg_wr(PCH_OFF_IO, 32'hffffffff);
    cfg_rd(PCH_OFF_IO, 32'hffffff01);
    $display("test io window done");
    cfg_wr(PCH_OFF_ROM, 32'h5555ffff);
    cfg_rd(PCH_OFF_ROM, 32'h55558000);
    cyc(PCH_CMD_MEM, 32'h5555ffff, 1'b1, PCH_WIN_ROM);
    cyc(PCH_CMD_MEM, 32'h55560000, 1'b0, PCH_WIN_NONE);
    cfg_wr(PCH_OFF_ROM, 32'hfffffffe);
    cfg_rd(PCH_OFF_ROM, 32'hffff8000);
    $display("test small rom window done");
    do_reset(1'b1, 1'b0);
    cfg_rd(PCH_OFF_CODES, codes(16'hfff8));
    cfg_rd(PCH_OFF_ROM, 32'hffff0000);
    cfg_rd(PCH_OFF_CAP, 32'h00000060);
    cfg_wr(PCH_OFF_ROM, 32'h5555ffff);
    cfg_rd(PCH_OFF_ROM, 32'h55550000);
    cyc(PCH_CMD_MEM, 32'h55550000, 1'b1, PCH_WIN_ROM);
    cfg_wr(PCH_OFF_ROM, 32'hfffffffe);
    cfg_rd(PCH_OFF_ROM, 32'hffff0000);
    $display("test large rom straps done");
    conclude();
  end
endmodule
